// ---- verilog/pin_ctrl_map.vh ----
// Bit positions, widths and reset values of the pin control register
`ifndef PIN_CTRL_MAP_VH
`define PIN_CTRL_MAP_VH
// ************************************************************
// Field positions
// ************************************************************
`define PC_WELL_LO      2
`define PC_WELL_HI      3
`define PC_DIR_BIT      9
`define PC_SRC_BIT      10
`define PC_POL_BIT      11
`define PC_MUX_LO       12
`define PC_MUX_HI       13
`define PC_INDIS_BIT    14
`define PC_OUT_BIT      16
`define PC_PAD_BIT      24
// ************************************************************
// Reset values and masks
// ************************************************************
`define PC_RESET_VAL    32'h00000000
`define PC_WMASK        32'h00017FFF
`define PC_MUX_GPIO     2'h0
`endif

// ---- verilog/pin_control.v ----
// Upper fields of one pin control register with its pin data path
`timescale 1ns/10ps
`include "pin_ctrl_map.vh"

// Contract
// - Bit 24 reads live pad, ignoring bit 10
// - Bit 24 reads high when well off
// - Source 0: bit 16 drives pin level
// - Source 1: bit 16 write ignored
// - Bit 16 reads last value written while stored bit 10 was clear
// - Bit 14 set disables input path
// - Polarity inverts alternate function output level, not its enable
// - Polarity inverts alternate interrupt sense
// - GPIO function ignores polarity on output
// - Grouped input reports pin uninverted
// - Bit 10 picks per-pin or grouped data
// - Mux zero means GPIO, else alternate
module pin_control (
    input  wire        CLK,
    input  wire        RESET,
    input  wire        REG_WR,
    input  wire [31:0] REG_WDATA,
    output reg  [31:0] REG_RDATA,
    input  wire        GROUP_OUT,
    output reg         GROUP_IN,
    input  wire [3:0]  WELL_ON,
    input  wire        PAD_IN,
    output reg         PAD_OUT,
    output reg         PAD_OE,
    input  wire        ALT_OUT,
    input  wire        ALT_OE,
    output reg         ALT_IN,
    input  wire        INT_SENSE,
    output reg         INT_SENSE_EFF
);

    // ************************************************************
    // Field decode helpers
    // ************************************************************
    // Mux value zero selects the plain GPIO function
    function is_gpio_mux;
        input [1:0] mux_val;
        begin
            is_gpio_mux = (mux_val == `PC_MUX_GPIO);
        end
    endfunction

    function sel_well;
        input [3:0] on;
        input [1:0] sel;
        begin
            sel_well = on[sel];
        end
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    reg  [31:0] ctrl_q;
    reg  [31:0] ctrl_d;

    // ************************************************************
    // Synchroniser nets
    // ************************************************************
    wire [4:0]  async_in;
    wire [4:0]  sync_bits;
    wire        pad_sync;
    wire [3:0]  well_sync;

    // ************************************************************
    // Decoded fields and next output values
    // ************************************************************
    wire [1:0]  mux_d;
    wire [1:0]  well_sel_q;
    wire        gpio_d;
    wire        gpio_q;
    wire        pol_d;
    wire        pol_q;
    wire        src_d;
    wire        out_bit_d;
    wire        dir_d;
    wire        indis_q;
    wire        well_off;
    wire        pad_seen;
    wire        gpio_level;
    wire        alt_level;
    wire        pad_out_d;
    wire        pad_oe_d;
    wire        int_sense_d;
    wire [31:0] rdata_d;

    // ************************************************************
    // Pad and well synchronisers
    // ************************************************************
    // Both pad and power-good come from outside the clock domain
    assign async_in  = {WELL_ON, PAD_IN};
    assign pad_sync  = sync_bits[0];
    assign well_sync = sync_bits[4:1];

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
            reg meta_q;
            reg sync_q;
            always @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[gi];
                    sync_q <= meta_q;
                end
            end
            assign sync_bits[gi] = sync_q;
        end
    endgenerate

    // ************************************************************
    // Field decode
    // ************************************************************
    // Pin side follows the next value so it moves with the readback
    assign mux_d      = ctrl_d[`PC_MUX_HI:`PC_MUX_LO];
    assign gpio_d     = is_gpio_mux(mux_d);
    assign gpio_q     = is_gpio_mux(ctrl_q[`PC_MUX_HI:`PC_MUX_LO]);
    assign pol_d      = ctrl_d[`PC_POL_BIT] & ~gpio_d;
    assign pol_q      = ctrl_q[`PC_POL_BIT] & ~gpio_q;
    assign src_d      = ctrl_d[`PC_SRC_BIT];
    assign out_bit_d  = ctrl_d[`PC_OUT_BIT];
    assign dir_d      = ctrl_d[`PC_DIR_BIT];
    assign well_sel_q = ctrl_q[`PC_WELL_HI:`PC_WELL_LO];
    assign indis_q    = ctrl_q[`PC_INDIS_BIT];

    // ************************************************************
    // Input path
    // ************************************************************
    assign well_off = ~sel_well(well_sync, well_sel_q);
    // Input disable gates the path; unpowered well forces high
    assign pad_seen = well_off | (pad_sync & ~indis_q);

    // ************************************************************
    // Output path
    // ************************************************************
    assign gpio_level  = src_d ? GROUP_OUT : out_bit_d;
    assign alt_level   = ALT_OUT ^ pol_d;
    assign pad_out_d   = gpio_d ? gpio_level : alt_level;
    assign pad_oe_d    = gpio_d ? dir_d : ALT_OE;
    assign int_sense_d = INT_SENSE ^ pol_d;

    // Write mask clears bit 24, so the live pad is simply merged in
    assign rdata_d = (ctrl_d & `PC_WMASK) | ({31'h0, pad_seen} << `PC_PAD_BIT);

    // ************************************************************
    // Write path
    // ************************************************************
    always @* begin
        ctrl_d = ctrl_q;
        if (REG_WR) begin
            ctrl_d = REG_WDATA & `PC_WMASK;
            // Lock uses the stored select, not the one being written
            if (ctrl_q[`PC_SRC_BIT])
                ctrl_d[`PC_OUT_BIT] = ctrl_q[`PC_OUT_BIT];
        end
    end

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_q <= `PC_RESET_VAL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= 32'h00000000;
        end else begin
            REG_RDATA <= rdata_d;
        end
    end

    // Grouped input never sees polarity
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            GROUP_IN <= 1'b0;
        end else begin
            GROUP_IN <= pad_seen;
        end
    end

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ALT_IN <= 1'b0;
        end else begin
            ALT_IN <= pad_seen;
        end
    end

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PAD_OUT <= 1'b0;
        end else begin
            PAD_OUT <= pad_out_d;
        end
    end

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            PAD_OE <= 1'b0;
        end else begin
            PAD_OE <= pad_oe_d;
        end
    end

    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            INT_SENSE_EFF <= 1'b0;
        end else begin
            INT_SENSE_EFF <= int_sense_d;
        end
    end

endmodule // pin_control

// ---- tb/pin_pad_model.sv ----
// Board pad model
`timescale 1ns/10ps
module pin_pad_model (input wire oe, input wire drv, input wire lvl, output wire pin);
assign pin = oe ? drv : lvl; // Board level only when pin not driven
endmodule // pin_pad_model

// ---- tb/pin_control_sva.sv ----
// Port checker for the pin control register
`timescale 1ns/10ps
module pin_control_sva (input wire CLK, RESET, REG_WR, GROUP_OUT, GROUP_IN, PAD_IN,
PAD_OUT, PAD_OE, ALT_OUT, ALT_OE, ALT_IN, INT_SENSE, INT_SENSE_EFF,
input wire [31:0] REG_WDATA, REG_RDATA, input wire [3:0] WELL_ON);
default clocking @(posedge CLK); endclocking
default disable iff (RESET);
wire [31:0] r = REG_RDATA;
wire alt = r[13:12] != 2'h0;
sequence s_wr; REG_WR && !r[10]; endsequence
a_rsv_zero: assert property ((r & 32'hFEFE8000) == 0) else $error("rsv");
a_wr_data: assert property (s_wr |=> r[16] == $past(REG_WDATA[16])) else $error("wr");
a_wr_lock: assert property (REG_WR && r[10] |=> $stable(r[16])) else $error("lk");
a_io_drive: assert property (!alt && !r[10] |-> PAD_OUT == r[16]) else $error("io");
a_grp_drive: assert property (!alt && r[10] |-> PAD_OUT == $past(GROUP_OUT))
else $error("gr");
a_alt_inv: assert property (alt |-> PAD_OUT == ($past(ALT_OUT) ^ r[11])) else $error("al");
a_int_inv: assert property (INT_SENSE_EFF == ($past(INT_SENSE) ^ (alt & r[11])))
else $error("in");
// Disable may gate the raw path, so only judged while it stays clear
a_raw_in: assert property (!$past(r[14]) && !$past(RESET, 3) && $past(WELL_ON, 3) == 4'hF
|-> GROUP_IN == $past(PAD_IN, 3))
else $error("raw");
endmodule // pin_control_sva
bind pin_control pin_control_sva pin_control_sva_inst (.*);

// ---- tb/pin_control_tb_top.sv ----
// Self-checking bench for the pin control register
`timescale 1ns/10ps
module pin_control_tb_top;
reg CLK = 0, RESET = 1, REG_WR = 0, GROUP_OUT = 0, ALT_OUT = 0, ALT_OE = 0, INT_SENSE = 0;
reg lvl = 0;
reg [31:0] REG_WDATA = 0;
reg [3:0] WELL_ON = 4'hF;
wire [31:0] REG_RDATA;
wire GROUP_IN, PAD_IN, PAD_OUT, PAD_OE, ALT_IN, INT_SENSE_EFF;
integer mismatches = 0, compares = 0;
pin_control pin_control_inst (.*);
pin_pad_model pin_pad_model_inst (.oe(PAD_OE), .drv(PAD_OUT), .lvl(lvl), .pin(PAD_IN));
initial forever #12.5 CLK = ~CLK;
task chk(input [31:0] s, e, input [23:0] n);
compares = compares + 1;
if (s !== e) begin
mismatches = mismatches + 1;
$display("FAIL %s expected %h seen %h", n, e, s);
end
endtask
// Four edges cover the pad sync latency
task wr(input [31:0] d);
REG_WDATA <= d; REG_WR <= 1'h1;
@(posedge CLK) REG_WR <= 1'h0;
repeat (4) @(posedge CLK);
endtask
task t_gpio;
wr(32'hFFFF8A00); chk(REG_RDATA, 32'h01010A00, "rd");
wr(32'h0A00); chk({REG_RDATA[24], PAD_OUT, PAD_OE}, 32'h1, "pin");
endtask
task t_lock;
wr(32'h10600); chk({REG_RDATA[16], PAD_OUT}, 32'h2, "lk");
GROUP_OUT <= 1'h1; wr(32'h0600); chk({REG_RDATA[16], PAD_OUT}, 32'h3, "lk");
endtask
task t_pad;
lvl <= 1'h1; wr(32'h0); chk({REG_RDATA[24], GROUP_IN}, 32'h3, "in");
lvl <= 1'h0; WELL_ON <= 4'h0; wr(32'h0); chk(REG_RDATA[24], 32'h1, "off");
lvl <= 1'h1; WELL_ON <= 4'hF; wr(32'h4000); chk(REG_RDATA[24], 32'h0, "dis");
endtask
task t_alt;
ALT_OUT <= 1'h1; ALT_OE <= 1'h1; INT_SENSE <= 1'h1; wr(32'h1800);
chk({PAD_OUT, INT_SENSE_EFF, GROUP_IN, ALT_IN, PAD_OE}, 32'h1, "alt");
endtask
task conclude;
if (mismatches == 0 && compares > 0) $display("No errors found");
else $display("Errors were found");
$finish;
endtask
initial begin
repeat (4) @(posedge CLK);
RESET <= 1'h0;
@(posedge CLK);
t_gpio;
t_lock;
t_pad;
t_alt;
conclude;
end
endmodule // pin_control_tb_top
